// >>> ddr_pkg.sv
/*
 * constants, carrier types and decode functions of the dual DAC register decoder.
 * assumes one system clock that oversamples the serial link pins.
 */
// Behaviour
// - a frame is 24 bits MSB first: rw, zero, group, channel address, 16 data.
// - channel address 000 picks A, 010 picks B, 100 picks both.
// - group 000 writes the data value of the addressed channel or channels.
// - data value is left aligned; low bits below the converter width are ignored.
// - group 001 stores a three bit range code from data bits 2..0.
// - range codes 000..101 are +5, +10, +10.8, -+5, -+10, -+10.8 volts.
// - group 011 is a control command chosen by the address field alone.
// - control address 000 is a filler command with no effect.
// - control address 001 stores option bits 3..0 from the data field.
// - control address 100 loads the clear code into both channels at once.
// - control address 101 moves pending input values to the outputs.
// - serial output off bit set disables the serial data output; default on.
// - clear level 0 gives 0 V; 1 gives midscale or negative full scale.
// - with current clamp enabled an overcurrent does not power the channel down.
// - with current clamp disabled an overcurrent powers the channel down.
// - thermal shutdown acts only while its enable bit is set; default off.
// - group 010 address 000 is power control with its fixed bit layout.
// - power up bit set runs the channel; cleared, the default, powers it down.
// - overtemperature powers both channels down and sets the thermal alert.
// - an overcurrent on a channel sets that channel's overcurrent alert bit.
package ddr_pkg;

	localparam int           FRAME_BITS = 24;
	localparam int           DATA_BITS  = 16;
	localparam int           DAC_BITS   = 16;
	localparam logic [4:0]   CNT_FRAME  = 5'h18;
	localparam logic [4:0]   CNT_MAX    = 5'h1F;

	localparam logic [2:0]   GRP_DATA   = 3'h0;
	localparam logic [2:0]   GRP_RANGE  = 3'h1;
	localparam logic [2:0]   GRP_POWER  = 3'h2;
	localparam logic [2:0]   GRP_CTRL   = 3'h3;

	localparam logic [2:0]   ADDR_A     = 3'h0;
	localparam logic [2:0]   ADDR_B     = 3'h2;
	localparam logic [2:0]   ADDR_BOTH  = 3'h4;

	localparam logic [2:0]   CTL_NO_OPERATION = 3'h0;
	localparam logic [2:0]   CTL_OPTIONS      = 3'h1;
	localparam logic [2:0]   CTL_CLEAR        = 3'h4;
	localparam logic [2:0]   CTL_LOAD         = 3'h5;

	localparam int           OPT_TSD_EN  = 3;
	localparam int           OPT_CLAMP   = 2;
	localparam int           OPT_CLR_SEL = 1;
	localparam int           OPT_SOUT    = 0;

	localparam int           PWR_PU_A   = 0;
	localparam int           PWR_PU_B   = 2;
	localparam int           PWR_THERM  = 5;
	localparam int           PWR_OC_A   = 7;
	localparam int           PWR_OC_B   = 9;

	localparam logic [2:0]   RNG_U5     = 3'h0;
	localparam logic [2:0]   RNG_U10    = 3'h1;
	localparam logic [2:0]   RNG_U108   = 3'h2;
	localparam logic [2:0]   RNG_B5     = 3'h3;
	localparam logic [2:0]   RNG_B10    = 3'h4;
	localparam logic [2:0]   RNG_B108   = 3'h5;

	localparam logic [15:0]  CODE_ZERO_UNI = 16'h0000;
	localparam logic [15:0]  CODE_ZERO_BIP = 16'h8000;
	localparam logic [15:0]  CODE_MID_UNI  = 16'h8000;
	localparam logic [15:0]  CODE_NEG_FS   = 16'h0000;
	localparam logic [15:0]  CODE_MASK     = 16'(16'hFFFF << (DATA_BITS - DAC_BITS));

	localparam logic [15:0]  RST_CODE    = 16'h0000;
	localparam logic [2:0]   RST_RANGE   = 3'h0;
	localparam logic [3:0]   RST_OPTIONS = 4'h4;
	localparam logic         RST_PU      = 1'b0;
	localparam logic [23:0]  RST_WORD    = 24'h000000;
	// pins in order {sclk, sync_n, data, load_n, oc_a, oc_b, overtemp}, idle levels
	localparam logic [6:0]   SYNC_INIT   = 7'h68;

	typedef struct packed {
		logic        rw;
		logic        zero;
		logic [2:0]  group;
		logic [2:0]  addr;
		logic [15:0] data;
	} ddr_frame_t;

	typedef struct packed {
		logic [15:0] code;
		logic [2:0]  range;
		logic        powered;
	} ddr_chan_t;

	typedef struct packed {
		logic tsd_en;
		logic clamp_en;
		logic clr_sel;
		logic sout_off;
	} ddr_opt_t;

	function automatic logic hit_a(input logic [2:0] addr);
		return (addr == ADDR_A) || (addr == ADDR_BOTH);
	endfunction

	function automatic logic hit_b(input logic [2:0] addr);
		return (addr == ADDR_B) || (addr == ADDR_BOTH);
	endfunction

	// offset binary coding is assumed for the bipolar ranges
	function automatic logic [15:0] clear_code(input logic [2:0] range, input logic sel);
		logic bip;
		bip = (range >= RNG_B5);
		if (!sel)
			return bip ? CODE_ZERO_BIP : CODE_ZERO_UNI;
		return bip ? CODE_NEG_FS : CODE_MID_UNI;
	endfunction

endpackage

// >>> ddr_sync.sv
/*
 * two flip-flop synchroniser for a vector of unrelated levels.
 * assumes each bit is an independent level; no word coherence across bits.
 */
`timescale 1ns/100ps
module ddr_sync #(
	parameter int          W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock_i,   // system clock
	input  wire logic         sys_rst_i, // async reset, high
	input  wire logic [W-1:0] async_i,   // levels from outside the domain
	output logic      [W-1:0] sync_o     // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// >>> ddr_shift.sv
/*
 * frame shifter: collects incoming bits and counts them, shifts the readback word out.
 * assumes one-cycle strobes already derived from the sampled serial clock.
 */
`timescale 1ns/100ps
module ddr_shift
	import ddr_pkg::*;
(
	input  wire logic               clock_i,    // system clock
	input  wire logic               sys_rst_i,  // async reset, high
	input  wire logic               start_i,    // frame opened, clears count
	input  wire logic               shift_in_i, // take bit_i
	input  wire logic               bit_i,      // serial input bit
	input  wire logic               load_out_i, // load out_word_i
	input  wire logic [23:0]        out_word_i, // readback word
	input  wire logic               shift_out_i,// advance output bit
	output ddr_pkg::ddr_frame_t     frame_o,    // last 24 bits received
	output logic      [4:0]         count_o,    // bits in this frame, saturating
	output logic                    bit_o       // serial output bit
);
	import ddr_pkg::*;

	logic [23:0] in_q;
	logic [4:0]  cnt_q;
	logic [23:0] out_q;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			in_q <= RST_WORD;
		else if (shift_in_i)
			in_q <= {in_q[22:0], bit_i};
	end

	// saturating so that an overlong frame never wraps back to a legal length
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			cnt_q <= 5'h00;
		else if (start_i)
			cnt_q <= 5'h00;
		else if (shift_in_i && cnt_q != CNT_MAX)
			cnt_q <= cnt_q + 5'h01;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			out_q <= RST_WORD;
		else if (load_out_i)
			out_q <= out_word_i;
		else if (shift_out_i)
			out_q <= {out_q[22:0], 1'b0};
	end

	assign frame_o = in_q;
	assign count_o = cnt_q;
	assign bit_o   = out_q[23];
endmodule

// >>> ddr_top.sv
/*
 * register decoder of a dual voltage output DAC behind its serial frame port.
 * assumes the serial pins and analog fault flags are asynchronous to clock_i,
 * and that clock_i runs several times faster than the serial clock.
 */
`timescale 1ns/100ps
module ddr_top
	import ddr_pkg::*;
(
	input  wire logic           clock_i,         // system clock, 100 MHz
	input  wire logic           sys_rst_i,       // async reset, high
	input  wire logic           link_sclk_i,     // serial clock pin
	input  wire logic           frame_sync_n_i,  // frame select pin, low in frame
	input  wire logic           serial_in_pin_i, // serial data in
	input  wire logic           load_n_i,        // load pin, low moves inputs out
	input  wire logic           overcurrent_a_i, // channel A overcurrent level
	input  wire logic           overcurrent_b_i, // channel B overcurrent level
	input  wire logic           overtemp_i,      // die overtemperature level
	output ddr_pkg::ddr_chan_t  chan_a_o,        // channel A code, range, power
	output ddr_pkg::ddr_chan_t  chan_b_o,        // channel B code, range, power
	output ddr_pkg::ddr_opt_t   options_o,       // option bits
	output logic                thermal_alert_o, // thermal alert flag
	output logic                serial_out_o,    // serial data out
	output logic                serial_out_oe_o  // serial out enable, high drives
);
	import ddr_pkg::*;

	logic [6:0]  pins_s;
	logic        sclk_s;
	logic        sync_n_s;
	logic        sin_s;
	logic        load_n_s;
	logic        oc_a_s;
	logic        oc_b_s;
	logic        ot_s;

	logic        sclk_q;
	logic        sync_n_q;
	logic        sclk_fall;
	logic        sclk_rise;
	logic        frame_start;
	logic        frame_end;

	ddr_frame_t  frm;
	logic [4:0]  count;
	logic        commit;
	logic        write_go;
	logic        read_go;
	logic        ctrl_go;
	logic        pwr_write;
	logic        therm_trip;

	ddr_opt_t    opts_q;
	logic [15:0] in_a_q;
	logic [15:0] in_b_q;
	logic [15:0] code_a_q;
	logic [15:0] code_b_q;
	logic [2:0]  range_a_q;
	logic [2:0]  range_b_q;
	logic        pu_a_q;
	logic        pu_b_q;
	logic        therm_q;
	logic        oc_a_q;
	logic        oc_b_q;
	logic [23:0] rb_q;
	logic [15:0] rb_data;
	logic [15:0] power_word;

	ddr_sync #(
		.W    (7),
		.INIT (SYNC_INIT)
	) u_sync (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({link_sclk_i, frame_sync_n_i, serial_in_pin_i, load_n_i,
		             overcurrent_a_i, overcurrent_b_i, overtemp_i}),
		.sync_o    (pins_s)
	);

	assign {sclk_s, sync_n_s, sin_s, load_n_s, oc_a_s, oc_b_s, ot_s} = pins_s;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sclk_q   <= SYNC_INIT[6];
			sync_n_q <= SYNC_INIT[5];
		end else begin
			sclk_q   <= sclk_s;
			sync_n_q <= sync_n_s;
		end
	end

	// both edges come through the same synchroniser delay, so their order holds
	assign sclk_fall   = sclk_q & ~sclk_s & ~sync_n_s;
	assign sclk_rise   = ~sclk_q & sclk_s & ~sync_n_s;
	assign frame_start = sync_n_q & ~sync_n_s;
	assign frame_end   = ~sync_n_q & sync_n_s;

	ddr_shift u_shift (
		.clock_i     (clock_i),
		.sys_rst_i   (sys_rst_i),
		.start_i     (frame_start),
		.shift_in_i  (sclk_fall),
		.bit_i       (sin_s),
		.load_out_i  (frame_start),
		.out_word_i  (rb_q),
		.shift_out_i (sclk_rise),
		.frame_o     (frm),
		.count_o     (count),
		.bit_o       (serial_out_o)
	);

	// a frame with the zero bit set is treated as corrupt and dropped
	assign commit    = frame_end && (count == CNT_FRAME) && !frm.zero;
	assign write_go  = commit && !frm.rw;
	assign read_go   = commit && frm.rw;
	assign ctrl_go   = write_go && (frm.group == GRP_CTRL);
	assign pwr_write = write_go && (frm.group == GRP_POWER) && (frm.addr == ADDR_A);
	assign therm_trip = opts_q.tsd_en && ot_s;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			opts_q <= RST_OPTIONS;
		else if (ctrl_go && frm.addr == CTL_OPTIONS)
			opts_q <= frm.data[3:0];
	end

	// pending input values; a clear also resets them so a later load cannot undo it
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_a_q <= RST_CODE;
			in_b_q <= RST_CODE;
		end else if (ctrl_go && frm.addr == CTL_CLEAR) begin
			in_a_q <= clear_code(range_a_q, opts_q.clr_sel);
			in_b_q <= clear_code(range_b_q, opts_q.clr_sel);
		end else if (write_go && frm.group == GRP_DATA) begin
			if (hit_a(frm.addr))
				in_a_q <= frm.data & CODE_MASK;
			if (hit_b(frm.addr))
				in_b_q <= frm.data & CODE_MASK;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			code_a_q <= RST_CODE;
			code_b_q <= RST_CODE;
		end else if (ctrl_go && frm.addr == CTL_CLEAR) begin
			code_a_q <= clear_code(range_a_q, opts_q.clr_sel);
			code_b_q <= clear_code(range_b_q, opts_q.clr_sel);
		end else if ((ctrl_go && frm.addr == CTL_LOAD) || !load_n_s) begin
			code_a_q <= in_a_q;
			code_b_q <= in_b_q;
		end
	end

	// codes 110 and 111 are stored as written; the analog side treats them as unused
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			range_a_q <= RST_RANGE;
			range_b_q <= RST_RANGE;
		end else if (write_go && frm.group == GRP_RANGE) begin
			if (hit_a(frm.addr))
				range_a_q <= frm.data[2:0];
			if (hit_b(frm.addr))
				range_b_q <= frm.data[2:0];
		end
	end

	// hardware power-down wins over a power-up written in the same cycle
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			pu_a_q <= RST_PU;
		else if (therm_trip || (!opts_q.clamp_en && oc_a_s))
			pu_a_q <= 1'b0;
		else if (pwr_write)
			pu_a_q <= frm.data[PWR_PU_A];
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			pu_b_q <= RST_PU;
		else if (therm_trip || (!opts_q.clamp_en && oc_b_s))
			pu_b_q <= 1'b0;
		else if (pwr_write)
			pu_b_q <= frm.data[PWR_PU_B];
	end

	// sticky; a power control write clears it, but a trip in that cycle wins
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			therm_q <= 1'b0;
		else if (therm_trip)
			therm_q <= 1'b1;
		else if (pwr_write)
			therm_q <= 1'b0;
	end

	// overcurrent alerts follow the fault and drop once it is removed
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			oc_a_q <= 1'b0;
			oc_b_q <= 1'b0;
		end else begin
			oc_a_q <= oc_a_s;
			oc_b_q <= oc_b_s;
		end
	end

	always_comb begin
		power_word = 16'h0000;
		power_word[PWR_PU_A]  = pu_a_q;
		power_word[PWR_PU_B]  = pu_b_q;
		power_word[PWR_THERM] = therm_q;
		power_word[PWR_OC_A]  = oc_a_q;
		power_word[PWR_OC_B]  = oc_b_q;
	end

	always_comb begin
		rb_data = 16'h0000;
		case (frm.group)
			GRP_DATA: begin
				rb_data = (frm.addr == ADDR_B) ? in_b_q : in_a_q;
			end
			GRP_RANGE: begin
				rb_data = {13'h0, (frm.addr == ADDR_B) ? range_b_q : range_a_q};
			end
			GRP_POWER: begin
				rb_data = power_word;
			end
			GRP_CTRL: begin
				if (frm.addr == CTL_OPTIONS)
					rb_data = {12'h000, opts_q};
			end
			default: begin
				rb_data = 16'h0000;
			end
		endcase
	end

	// the readback word is handed to the shifter when the next frame opens
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rb_q <= RST_WORD;
		else if (read_go)
			rb_q <= {frm.rw, frm.zero, frm.group, frm.addr, rb_data};
		else if (frame_start)
			rb_q <= RST_WORD;
	end

	assign serial_out_oe_o = !opts_q.sout_off && !sync_n_s;

	assign chan_a_o        = '{code: code_a_q, range: range_a_q, powered: pu_a_q};
	assign chan_b_o        = '{code: code_b_q, range: range_b_q, powered: pu_b_q};
	assign options_o       = opts_q;
	assign thermal_alert_o = therm_q;

	property p_len;
		@(posedge clock_i) disable iff (sys_rst_i)
		(frame_end && count != CNT_FRAME) |=> $stable(opts_q) && $stable(in_a_q)
			&& $stable(range_a_q);
	endproperty
	a_len: assert property (p_len) else $error("short or long frame took effect");

	property p_data_a;
		@(posedge clock_i) disable iff (sys_rst_i)
		(write_go && frm.group == GRP_DATA && frm.addr == ADDR_A)
			|=> in_a_q == ($past(frm.data) & CODE_MASK) && $stable(in_b_q);
	endproperty
	a_data_a: assert property (p_data_a) else $error("channel A data not stored");

	property p_both;
		@(posedge clock_i) disable iff (sys_rst_i)
		(write_go && frm.group == GRP_DATA && frm.addr == ADDR_BOTH)
			|=> in_a_q == in_b_q && in_b_q == ($past(frm.data) & CODE_MASK);
	endproperty
	a_both: assert property (p_both) else $error("both channel write mismatched");

	property p_range;
		@(posedge clock_i) disable iff (sys_rst_i)
		(write_go && frm.group == GRP_RANGE && frm.addr == ADDR_B)
			|=> range_b_q == $past(frm.data[2:0]) && $stable(range_a_q);
	endproperty
	a_range: assert property (p_range) else $error("range code not stored");

	property p_opts;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ctrl_go && frm.addr == CTL_OPTIONS) |=> opts_q == $past(frm.data[3:0]);
	endproperty
	a_opts: assert property (p_opts) else $error("option bits not stored");

	property p_clear;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ctrl_go && frm.addr == CTL_CLEAR)
			|=> code_a_q == clear_code(range_a_q, opts_q.clr_sel)
			&& code_b_q == clear_code(range_b_q, opts_q.clr_sel);
	endproperty
	a_clear: assert property (p_clear) else $error("clear code not applied");

	property p_load;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ctrl_go && frm.addr == CTL_LOAD) |=> code_a_q == $past(in_a_q)
			&& code_b_q == $past(in_b_q);
	endproperty
	a_load: assert property (p_load) else $error("load did not move inputs");

	property p_sout;
		@(posedge clock_i) disable iff (sys_rst_i)
		opts_q.sout_off |-> !serial_out_oe_o;
	endproperty
	a_sout: assert property (p_sout) else $error("serial output driven while off");

	property p_oc_down;
		@(posedge clock_i) disable iff (sys_rst_i)
		(!opts_q.clamp_en && oc_a_s) |=> !pu_a_q;
	endproperty
	a_oc_down: assert property (p_oc_down) else $error("overcurrent left A powered");

	property p_clamp;
		@(posedge clock_i) disable iff (sys_rst_i)
		(opts_q.clamp_en && pu_a_q && !therm_trip && !pwr_write) |=> pu_a_q;
	endproperty
	a_clamp: assert property (p_clamp) else $error("A powered down under clamp");

	property p_therm;
		@(posedge clock_i) disable iff (sys_rst_i)
		therm_trip |=> !pu_a_q && !pu_b_q && thermal_alert_o;
	endproperty
	a_therm: assert property (p_therm) else $error("thermal trip not handled");

	property p_oc_flag;
		@(posedge clock_i) disable iff (sys_rst_i)
		$rose(oc_b_s) |=> power_word[PWR_OC_B] ##1 (power_word[PWR_OC_B] || !oc_b_s);
	endproperty
	a_oc_flag: assert property (p_oc_flag) else $error("B overcurrent alert missing");

	property p_no_op;
		@(posedge clock_i) disable iff (sys_rst_i)
		(ctrl_go && frm.addr == CTL_NO_OPERATION) |=> $stable(opts_q)
			&& $stable(in_a_q) && $stable(in_b_q);
	endproperty
	a_no_op: assert property (p_no_op) else $error("filler command changed state");

endmodule

// >>> ddr_host_model.sv
/*
 * host side of the serial frame port: shifts command frames in, samples readback.
 * assumes the bench clock; pins change 1 ns after a clock edge.
 */
`timescale 1ns/100ps
module ddr_host_model (
	input  wire logic clock_i,         // bench clock, pacing only
	input  wire logic serial_out_i,    // readback bit from the block
	input  wire logic serial_out_oe_i, // readback enable
	output logic      link_sclk_o,     // serial clock, idle high
	output logic      frame_sync_n_o,  // frame select, low in frame
	output logic      serial_in_pin_o  // serial data
);
	logic [23:0] rd_word;
	logic        oe_seen;

	initial begin
		link_sclk_o     = 1'b1;
		frame_sync_n_o  = 1'b1;
		serial_in_pin_o = 1'b0;
		rd_word         = 24'h000000;
		oe_seen         = 1'b0;
	end

	task automatic half();
		repeat (4) @(posedge clock_i);
		#1;
	endtask

	// n below 24 makes a short frame on purpose
	task automatic send(input logic [23:0] w, input int n);
		oe_seen        = 1'b0;
		frame_sync_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in_pin_o = w[23-i];
			half();
			link_sclk_o = 1'b0;
			rd_word     = {rd_word[22:0], serial_out_oe_i ? serial_out_i : ~serial_out_i};
			oe_seen     = oe_seen | serial_out_oe_i;
			half();
			link_sclk_o = 1'b1;
		end
		half();
		frame_sync_n_o  = 1'b1;
		// released line shows the inverse so a stale bit cannot pass
		serial_in_pin_o = ~serial_in_pin_o;
		repeat (6) @(posedge clock_i);
		#1;
	endtask
endmodule

// >>> ddr_top_tb_top.sv
/*
 * self-checking bench of the register decoder, frames sent through the host model.
 * assumes the decoder answers within 4 clocks of a frame close or a fault change.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ddr_top_tb_top;
	import ddr_pkg::*;
	logic               clock_i, sys_rst_i, load_n_i, oc_a, oc_b, overtemp;
	logic               sclk, sync_n, sdi, sdo, sdo_oe, thermal_alert;
	ddr_pkg::ddr_chan_t chan_a, chan_b;
	ddr_pkg::ddr_opt_t  options;
	int                 n_mismatch, comparisons, cycles;

	ddr_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link_sclk_i(sclk),
		.frame_sync_n_i(sync_n), .serial_in_pin_i(sdi), .load_n_i(load_n_i),
		.overcurrent_a_i(oc_a), .overcurrent_b_i(oc_b), .overtemp_i(overtemp),
		.chan_a_o(chan_a), .chan_b_o(chan_b), .options_o(options),
		.thermal_alert_o(thermal_alert), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe));
	ddr_host_model host (.clock_i(clock_i), .serial_out_i(sdo), .serial_out_oe_i(sdo_oe),
		.link_sclk_o(sclk), .frame_sync_n_o(sync_n), .serial_in_pin_o(sdi));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	function automatic logic [23:0] fr(logic rw, logic [2:0] g, logic [2:0] a, logic [15:0] d);
		return {rw, 1'b0, g, a, d};
	endfunction

	task automatic clks(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic final_report();
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic t_reset();
		`CHK(chan_a, 20'h00000)
		`CHK(chan_b, 20'h00000)
		`CHK(options, 4'h4)
		`CHK(sdo_oe, 1'b0)
		$display("test reset done");
	endtask

	task automatic t_data();
		host.send(fr(0, GRP_DATA, ADDR_BOTH, 16'h5555), 24);
		host.send(fr(0, GRP_DATA, ADDR_A, 16'h1234), 24);
		`CHK(chan_a.code, 16'h0000)
		host.send(fr(0, GRP_DATA, ADDR_B, 16'hEEEE), 23);
		host.send({2'b01, GRP_DATA, ADDR_B, 16'hEEEE}, 24);
		host.send(fr(0, GRP_CTRL, CTL_LOAD, 16'hFFFF), 24);
		`CHK(chan_a.code, 16'h1234)
		`CHK(chan_b.code, 16'h5555)
		host.send(fr(0, GRP_DATA, ADDR_B, 16'h9ABC), 24);
		load_n_i = 1'b0;
		clks(3);
		load_n_i = 1'b1;
		clks(4);
		`CHK(chan_b.code, 16'h9ABC)
		`CHK(chan_a.code, 16'h1234)
		host.send(fr(1, GRP_DATA, ADDR_B, 16'h0000), 24);
		host.send(fr(0, GRP_CTRL, CTL_NO_OPERATION, 16'h0000), 24);
		`CHK(host.rd_word, 24'h829ABC)
		$display("test data done");
	endtask

	task automatic t_range();
		for (int i = 0; i < 6; i++) begin
			host.send(fr(0, GRP_RANGE, ADDR_B, {13'h1FFF, 3'(i)}), 24);
			`CHK(chan_b.range, 3'(i))
		end
		host.send(fr(0, GRP_RANGE, ADDR_B, 16'hFFFC), 24);
		host.send(fr(0, GRP_RANGE, ADDR_A, 16'hFFF9), 24);
		`CHK(chan_a.range, RNG_U10)
		`CHK(chan_b.range, RNG_B10)
		host.send(fr(1, GRP_RANGE, ADDR_B, 16'h0000), 24);
		host.send(fr(0, GRP_CTRL, CTL_NO_OPERATION, 16'h0000), 24);
		`CHK(host.rd_word, 24'h8A0004)
		$display("test range done");
	endtask

	task automatic t_clear();
		host.send(fr(0, GRP_CTRL, CTL_OPTIONS, 16'hFFF2), 24);
		`CHK(options, 4'h2)
		host.send(fr(1, GRP_CTRL, CTL_OPTIONS, 16'h0000), 24);
		host.send(fr(0, GRP_CTRL, CTL_NO_OPERATION, 16'hFFFF), 24);
		`CHK(host.rd_word, 24'h990002)
		`CHK(options, 4'h2)
		`CHK(chan_b.code, 16'h9ABC)
		`CHK(host.oe_seen, 1'b1)
		host.send(fr(0, GRP_CTRL, CTL_CLEAR, 16'h0000), 24);
		`CHK(chan_a.code, 16'h8000)
		`CHK(chan_b.code, 16'h0000)
		host.send(fr(0, GRP_CTRL, CTL_OPTIONS, 16'h0001), 24);
		host.send(fr(0, GRP_CTRL, CTL_CLEAR, 16'h0000), 24);
		`CHK(host.oe_seen, 1'b0)
		`CHK(chan_a.code, 16'h0000)
		`CHK(chan_b.code, 16'h8000)
		$display("test clear done");
	endtask

	task automatic t_power();
		host.send(fr(0, GRP_CTRL, CTL_OPTIONS, 16'h0000), 24);
		host.send(fr(0, GRP_POWER, ADDR_A, 16'h0005), 24);
		`CHK({chan_a.powered, chan_b.powered}, 2'b11)
		oc_a = 1'b1;
		clks(5);
		`CHK({chan_a.powered, chan_b.powered}, 2'b01)
		host.send(fr(1, GRP_POWER, ADDR_A, 16'h0000), 24);
		host.send(fr(0, GRP_CTRL, CTL_NO_OPERATION, 16'h0000), 24);
		`CHK(host.rd_word, 24'h900084)
		oc_a = 1'b0;
		host.send(fr(0, GRP_CTRL, CTL_OPTIONS, 16'h0004), 24);
		host.send(fr(0, GRP_POWER, ADDR_A, 16'h0005), 24);
		oc_b = 1'b1;
		clks(5);
		`CHK(chan_b.powered, 1'b1)
		oc_b     = 1'b0;
		overtemp = 1'b1;
		clks(5);
		`CHK({thermal_alert, chan_a.powered}, 2'b01)
		overtemp = 1'b0;
		host.send(fr(0, GRP_CTRL, CTL_OPTIONS, 16'h000C), 24);
		overtemp = 1'b1;
		clks(5);
		`CHK({thermal_alert, chan_a.powered, chan_b.powered}, 3'b100)
		overtemp = 1'b0;
		$display("test power done");
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		n_mismatch  = 0;
		comparisons = 0;
		cycles      = 0;
		sys_rst_i   = 1'b1;
		load_n_i    = 1'b1;
		oc_a        = 1'b0;
		oc_b        = 1'b0;
		overtemp    = 1'b0;
		clks(8);
		sys_rst_i = 1'b0;
		clks(4);
		t_reset();
		t_data();
		t_range();
		t_clear();
		t_power();
		final_report();
	end
endmodule
